// ==== common/tx_pcc_defines.svh ====
`ifndef TX_PCC_DEFINES_SVH
`define TX_PCC_DEFINES_SVH

// ****************************************************************
// direct register offsets
// ****************************************************************
`define OFS_CONFIG          8'h6C
`define OFS_ACCESS_STATUS   8'h6D
`define OFS_ADDR_CONTROL    8'h6E
`define OFS_DATA_BUFFER     8'h6F

// ****************************************************************
// field positions
// ****************************************************************
`define CFG_PERCHANNEL_ENABLE_BIT        0
`define CFG_IND_BIT         1
`define CFG_RSVD_BIT        2
`define STATUS_BUSY_BIT     7
`define ADDR_DIR_BIT        7
`define CTRL_INVERT_BIT     7
`define CTRL_IDLE_BIT       6
`define CTRL_MW_BIT         5
`define CTRL_SIGN_BIT       4
`define CTRL_TEST_BIT       3
`define CTRL_LOOP_BIT       2
`define CTRL_ZCS_HI_BIT     1
`define CTRL_ZCS_LO_BIT     0

// ****************************************************************
// internal address banks
// ****************************************************************
`define BANK_CTRL_BASE      7'h20
`define BANK_IDLE_BASE      7'h40
`define BANK_SIG_BASE       7'h60

// ****************************************************************
// reset values
// ****************************************************************
`define RST_CONFIG          3'h0
`define RST_ADDR_CONTROL    8'h00
`define RST_DATA_BUFFER     8'h00

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS       10
`define ACCESS_MAX_NS       640
`define ACCESS_CYCLES       (`ACCESS_MAX_NS / `CLK_PERIOD_NS)

`endif

// ==== common/tx_pcc_pkg.sv ====
package tx_pcc_pkg;

	typedef logic [7:0] byte_t;

	typedef enum logic [1:0] {
		ACC_IDLE  = 2'b00,
		ACC_READ  = 2'b01,
		ACC_WRITE = 2'b10
	} access_state_e;

endpackage

// ==== hw/pcm_bit_cond.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tx_pcc_defines.svh"

module pcm_bit_cond (
	input  wire logic [7:0] ctrl,
	input  wire logic [7:0] idle_code,
	input  wire logic [7:0] mw_code,
	input  wire logic [2:0] bit_idx,
	input  wire logic       t1_active,
	input  wire logic       perchannel_enable,
	input  wire logic       pcm_bit,
	input  wire logic       loop_bit,
	input  wire logic       test_bit,
	input  wire logic       test_gen,
	output logic            out_bit
);

	logic [2:0] sel;
	logic       flip;

	// bit 0 of the channel carries byte bit 7
	assign sel = 3'h7 - bit_idx; // RQ19

	always_comb
	begin
		if (bit_idx == 3'h0)
			flip = ctrl[`CTRL_SIGN_BIT] ^ ctrl[`CTRL_INVERT_BIT]; // RQ13 RQ14
		else
			flip = ctrl[`CTRL_INVERT_BIT]; // RQ10 RQ14
	end

	// loopback, milliwatt, test, idle, then inversion
	always_comb
	begin
		if (!perchannel_enable)
			out_bit = pcm_bit; // RQ17
		else if (ctrl[`CTRL_LOOP_BIT])
			out_bit = loop_bit; // RQ9 RQ16
		else if (!t1_active)
			out_bit = pcm_bit;
		else if (ctrl[`CTRL_MW_BIT])
			out_bit = mw_code[sel]; // RQ15 RQ16
		else if (ctrl[`CTRL_TEST_BIT] && test_gen)
			out_bit = test_bit; // RQ16
		else if (ctrl[`CTRL_IDLE_BIT])
			out_bit = idle_code[sel]; // RQ11 RQ19
		else
			out_bit = pcm_bit ^ flip; // RQ16
	end

endmodule
`default_nettype wire

// ==== hw/tx_perchannel_indirect_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tx_pcc_defines.svh"

// Functional notes
// [RQ1] Busy flag, status bit 7, high from request start until completion.
// [RQ2] Host polls busy low before starting another indirect access.
// [RQ3] Any indirect read or write finishes within 640 ns.
// [RQ4] Address/control write with valid address starts one internal access.
// [RQ5] Direction bit 7: one reads, zero writes.
// [RQ6] Host loads data buffer before writing address with direction zero.
// [RQ7] Read data lands in data buffer within 640 ns.
// [RQ8] Banks: control 20H-3FH, idle 40H-5FH, signaling 60H-7FH, one per slot.
// [RQ9] Control byte: invert, idle, milliwatt, sign, test, loop, two zero-suppress.
// [RQ10] Full invert flips whole channel, T1 only.
// [RQ11] Idle bit substitutes channel idle code, T1 only.
// [RQ12] Fractional mode: eight clock pulses unless idle bit set, then gapped.
// [RQ13] Sign invert flips only the channel msb, T1 only.
// [RQ14] Both inversions flip all bits except msb.
// [RQ15] Milliwatt bit replaces channel with milliwatt pattern, T1 only.
// [RQ16] Priority: loopback, milliwatt, test, idle, inversion last.
// [RQ17] Per-channel bytes act only while per-channel enable is one.
// [RQ18] Host sets indirect mode bit; reset clears it, disabling access.
// [RQ19] Idle code goes out msb first.
// [RQ20] Address below 20H completes; writes ignored, reads unspecified.
// [RQ21] Completed write applies from the channel's next occurrence.
module tx_perchannel_indirect_ctrl #(
	parameter int          NUM_SLOTS  = 32,
	parameter logic [63:0] MW_PATTERN = 64'h0
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       link_clk,
	input  wire logic       link_frame,
	input  wire logic       backplane_tx_pcm,
	input  wire logic       loop_pcm,
	input  wire logic       test_pcm,
	input  wire logic       test_gen,
	input  wire logic       e1_mode,
	input  wire logic       fractional_channel_mode,
	output logic            tx_pcm_out,
	output logic            backplane_tx_clock_en
);

	// ****************************************************************
	// checks
	// ****************************************************************
	generate
		if (NUM_SLOTS != 32)
		begin : g_bad
			$error("slot count must be 32");
		end
	endgenerate

	localparam int ACC_CNT = `ACCESS_CYCLES;

	function automatic logic in_banks(input logic [6:0] a);
		in_banks = (a >= `BANK_CTRL_BASE);
	endfunction

	// ****************************************************************
	// host registers
	// ****************************************************************
	logic [2:0]                  cfg_q;
	logic [7:0]                  addr_ctrl_q;
	logic [7:0]                  data_buf_q;
	logic [7:0]                  rdata_q;
	tx_pcc_pkg::access_state_e   acc_q;
	logic [6:0]                  acc_cnt_q;
	tx_pcc_pkg::byte_t           mem_q [0:3*NUM_SLOTS-1];
	logic                        start;
	logic                        busy;
	logic                        upd_req_q;
	logic [6:0]                  upd_addr_q;
	logic [7:0]                  upd_data_q;
	logic [1:0]                  ack_sync_q;
	logic                        ack_seen_q;
	logic                        ack_event;
	logic [6:0]                  mem_idx;

	assign busy = (acc_q != tx_pcc_pkg::ACC_IDLE);
	assign start = reg_wr && (reg_addr == `OFS_ADDR_CONTROL) && !busy
		&& cfg_q[`CFG_IND_BIT]; // RQ4 RQ18
	assign mem_idx = addr_ctrl_q[6:0] - `BANK_CTRL_BASE;
	assign ack_event = ack_sync_q[1] ^ ack_seen_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cfg_q <= `RST_CONFIG;
		else if (reg_wr && reg_addr == `OFS_CONFIG)
			cfg_q <= reg_wdata[2:0];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			addr_ctrl_q <= `RST_ADDR_CONTROL;
		else if (reg_wr && reg_addr == `OFS_ADDR_CONTROL && !busy)
			addr_ctrl_q <= reg_wdata;
	end

	// read result lands in the buffer; host writes blocked while busy
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			data_buf_q <= `RST_DATA_BUFFER;
		else if (acc_q == tx_pcc_pkg::ACC_READ)
			data_buf_q <= in_banks(addr_ctrl_q[6:0]) ? mem_q[mem_idx] : 8'h00; // RQ7 RQ20
		else if (reg_wr && reg_addr == `OFS_DATA_BUFFER && !busy)
			data_buf_q <= reg_wdata; // RQ6
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				`OFS_CONFIG:        rdata_q <= {5'h00, cfg_q};
				`OFS_ACCESS_STATUS: rdata_q <= {busy, 7'h00}; // RQ1
				`OFS_ADDR_CONTROL:  rdata_q <= addr_ctrl_q;
				`OFS_DATA_BUFFER:   rdata_q <= data_buf_q;
				default:            rdata_q <= 8'h00;
			endcase
		end
	end

	assign reg_rdata = rdata_q;

	// ****************************************************************
	// access sequencer
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_q <= tx_pcc_pkg::ACC_IDLE;
			acc_cnt_q <= 7'h00;
		end
		else
		begin
			case (acc_q)
				tx_pcc_pkg::ACC_IDLE:
				begin
					acc_cnt_q <= 7'h00;
					if (start && reg_wdata[`ADDR_DIR_BIT])
						acc_q <= tx_pcc_pkg::ACC_READ; // RQ5
					else if (start)
						acc_q <= tx_pcc_pkg::ACC_WRITE; // RQ5
				end
				tx_pcc_pkg::ACC_READ:
					acc_q <= tx_pcc_pkg::ACC_IDLE; // RQ1 RQ3
				tx_pcc_pkg::ACC_WRITE:
				begin
					acc_cnt_q <= acc_cnt_q + 7'h01;
					if (!in_banks(addr_ctrl_q[6:0]) || ack_event
						|| acc_cnt_q >= 7'(ACC_CNT - 3))
						acc_q <= tx_pcc_pkg::ACC_IDLE; // RQ1 RQ3 RQ20
				end
				default:
					acc_q <= tx_pcc_pkg::ACC_IDLE;
			endcase
		end
	end

	// host-side copy of all 96 bytes, served for reads
	always_ff @(posedge clk)
	begin
		if (acc_q == tx_pcc_pkg::ACC_IDLE && start && !reg_wdata[`ADDR_DIR_BIT]
			&& in_banks(reg_wdata[6:0]))
			mem_q[7'(reg_wdata[6:0] - `BANK_CTRL_BASE)] <= data_buf_q; // RQ8 RQ20
	end

	// word handshake toward the link domain
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			upd_req_q <= 1'b0;
			upd_addr_q <= 7'h00;
			upd_data_q <= 8'h00;
		end
		else if (acc_q == tx_pcc_pkg::ACC_IDLE && start && !reg_wdata[`ADDR_DIR_BIT]
			&& in_banks(reg_wdata[6:0]))
		begin
			upd_req_q <= ~upd_req_q; // RQ21
			upd_addr_q <= reg_wdata[6:0];
			upd_data_q <= data_buf_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_sync_q <= 2'b00;
			ack_seen_q <= 1'b0;
		end
		else
		begin
			ack_sync_q <= {ack_sync_q[0], upd_ack_q};
			ack_seen_q <= ack_sync_q[1];
		end
	end

	// ****************************************************************
	// link domain
	// ****************************************************************
	logic [1:0] req_sync_q;
	logic       req_seen_q;
	logic       upd_ack_q;
	logic [2:0] lvl_sync0_q;
	logic [2:0] lvl_sync1_q;
	logic       l_perchannel_enable;
	logic       l_e1;
	logic       l_frac;
	logic [7:0] ctrl_l_q [0:NUM_SLOTS-1];
	logic [7:0] idle_l_q [0:NUM_SLOTS-1];
	logic [2:0] bit_q;
	logic [4:0] slot_q;
	logic [2:0] mw_phase_q;
	logic [7:0] cur_ctrl_q;
	logic [7:0] cur_idle_q;
	logic [2:0] bit_now;
	logic [4:0] slot_now;
	logic [7:0] ctrl_now;
	logic [7:0] idle_now;
	logic       cond_bit;
	logic       tx_pcm_q;
	logic       clk_en_q;

	// two-flop level crossing of mode pins and the per-channel enable config bit
	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lvl_sync0_q <= 3'h0;
			lvl_sync1_q <= 3'h0;
		end
		else
		begin
			lvl_sync0_q <= {fractional_channel_mode, e1_mode,
				cfg_q[`CFG_PERCHANNEL_ENABLE_BIT]};
			lvl_sync1_q <= lvl_sync0_q;
		end
	end

	assign l_perchannel_enable = lvl_sync1_q[0];
	assign l_e1   = lvl_sync1_q[1];
	assign l_frac = lvl_sync1_q[2];

	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_sync_q <= 2'b00;
			req_seen_q <= 1'b0;
			upd_ack_q <= 1'b0;
		end
		else
		begin
			req_sync_q <= {req_sync_q[0], upd_req_q};
			req_seen_q <= req_sync_q[1];
			if (req_sync_q[1] ^ req_seen_q)
				upd_ack_q <= ~upd_ack_q;
		end
	end

	// address and data held stable while the request toggle is in flight
	always_ff @(posedge link_clk)
	begin
		if ((req_sync_q[1] ^ req_seen_q) && upd_addr_q[6:5] == 2'b01)
			ctrl_l_q[upd_addr_q[4:0]] <= upd_data_q; // RQ8 RQ21
		if ((req_sync_q[1] ^ req_seen_q) && upd_addr_q[6:5] == 2'b10)
			idle_l_q[upd_addr_q[4:0]] <= upd_data_q; // RQ8 RQ21
	end

	// bit and slot position; frame pulse marks slot 0 bit 0
	assign bit_now  = link_frame ? 3'h0 : bit_q;
	assign slot_now = link_frame ? 5'h00 : slot_q;
	assign ctrl_now = (bit_now == 3'h0) ? ctrl_l_q[slot_now] : cur_ctrl_q; // RQ21
	assign idle_now = (bit_now == 3'h0) ? idle_l_q[slot_now] : cur_idle_q;

	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_q <= 3'h0;
			slot_q <= 5'h00;
			mw_phase_q <= 3'h0;
		end
		else
		begin
			bit_q <= bit_now + 3'h1;
			if (bit_now == 3'h7)
				slot_q <= slot_now + 5'h01;
			else
				slot_q <= slot_now;
			if (bit_now == 3'h7 && slot_now == 5'h1F)
				mw_phase_q <= mw_phase_q + 3'h1;
		end
	end

	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur_ctrl_q <= 8'h00;
			cur_idle_q <= 8'h00;
		end
		else
		begin
			cur_ctrl_q <= ctrl_now;
			cur_idle_q <= idle_now;
		end
	end

	pcm_bit_cond u_cond (
		.ctrl      (ctrl_now),
		.idle_code (idle_now),
		.mw_code   (MW_PATTERN[{mw_phase_q, 3'h0} +: 8]),
		.bit_idx   (bit_now),
		.t1_active (!l_e1),
		.perchannel_enable      (l_perchannel_enable),
		.pcm_bit   (backplane_tx_pcm),
		.loop_bit  (loop_pcm),
		.test_bit  (test_pcm),
		.test_gen  (test_gen),
		.out_bit   (cond_bit)
	);

	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_pcm_q <= 1'b0;
			clk_en_q <= 1'b1;
		end
		else
		begin
			tx_pcm_q <= cond_bit; // RQ10 RQ11 RQ13 RQ15 RQ16 RQ17
			clk_en_q <= !(l_frac && l_perchannel_enable && ctrl_now[`CTRL_IDLE_BIT]); // RQ12 RQ17
		end
	end

	assign tx_pcm_out = tx_pcm_q;
	assign backplane_tx_clock_en = clk_en_q;

endmodule
`default_nettype wire

// ==== testbench/test_tx_perchannel_indirect_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_tx_perchannel_indirect_ctrl;
	logic       clk, rst_n, reg_wr, reg_rd, link_clk, frame, pcm, pcm_out, en, e1, frac;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, pos, ix, d;
	logic [7:0] ob [32];
	logic [7:0] oe [32];
	int         error_cnt, checks_done;
	localparam logic [7:0] CTL [10] = '{8'h00, 8'h80, 8'h10, 8'h90, 8'h40,
		8'h20, 8'h60, 8'h00, 8'h24, 8'h44};
	localparam logic [7:0] XD [10] = '{8'h5C, 8'hA2, 8'hDE, 8'h20, 8'hC1,
		8'hA5, 8'hA5, 8'h5B, 8'hAB, 8'hAA};
	localparam logic [7:0] XE [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00,
		8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00};
	tx_perchannel_indirect_ctrl #(.NUM_SLOTS(32), .MW_PATTERN(64'hA5A5A5A5A5A5A5A5))
		tx_perchannel_indirect_ctrl_inst (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.link_clk(link_clk), .link_frame(frame), .backplane_tx_pcm(pcm),
		.loop_pcm(~pcm), .test_pcm(1'b0), .test_gen(1'b0), .e1_mode(e1),
		.fractional_channel_mode(frac), .tx_pcm_out(pcm_out),
		.backplane_tx_clock_en(en));
	tx_pcm_source tx_pcm_source_inst (.link_clk(link_clk), .rst_n(rst_n),
		.pos(pos), .frame(frame), .pcm(pcm));
	// **********
	// clocks and output capture, output lags input by one link cycle
	// **********
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end
	assign ix = pos - 8'h01;
	always @(posedge link_clk)
	begin
		ob[ix[7:3]][3'h7 - ix[2:0]] <= pcm_out;
		oe[ix[7:3]][3'h7 - ix[2:0]] <= en;
	end
	// **********
	// tasks
	// **********
	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask
	task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(n, e, d);
	endtask
	task automatic waitc(input logic [6:0] a);
		int k;
		rd(8'h6D);
		if (a >= 7'h20)
			chk("busy set", 8'h80, d);
		k = 0;
		while (d[7] !== 1'b0 && k < 40)
		begin
			rd(8'h6D);
			k++;
		end
		chk("busy clear", 8'h00, d);
	endtask
	task automatic iw(input logic [6:0] a, input logic [7:0] v);
		@(negedge clk);
		wr(8'h6F, v);
		@(negedge clk);
		wr(8'h6E, {1'b0, a});
		waitc(a);
	endtask
	task automatic ir(input string n, input logic [6:0] a, input logic [7:0] e);
		wr(8'h6E, {1'b1, a});
		waitc(a);
		rc(n, 8'h6F, e);
	endtask
	// **********
	// sequence
	// **********
	initial
	begin
		#200000;
		error_cnt++;
		test_done;
	end
	initial
	begin
		{rst_n, reg_wr, reg_rd, e1, frac} = 5'b00001;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		rc("config", 8'h6C, 8'h00);
		rc("addr ctrl", 8'h6E, 8'h00);
		rc("data buffer", 8'h6F, 8'h00);
		rc("unmapped", 8'h10, 8'h00);
		wr(8'h6E, 8'hA5);
		rc("busy mode off", 8'h6D, 8'h00);
		wr(8'h6C, 8'h02);
		for (int i = 0; i < 32; i++)
		begin
			iw(7'h20 + 7'(i), i < 10 ? CTL[i] : 8'h00);
			iw(7'h40 + 7'(i), 8'hC1);
		end
		iw(7'h63, 8'h5A);
		iw(7'h05, 8'h77);
		ir("ctrl byte", 7'h23, 8'h90);
		ir("idle byte", 7'h44, 8'hC1);
		ir("sig byte", 7'h63, 8'h5A);
		rc("addr ctrl back", 8'h6E, 8'hE3);
		wr(8'h6F, 8'hC3);
		rc("buffer", 8'h6F, 8'hC3);
		wr(8'h6C, 8'h03);
		repeat (600) @(negedge clk);
		for (int i = 0; i < 10; i++)
		begin
			chk("slot data", XD[i], ob[i]);
			chk("slot clock", XE[i], oe[i]);
		end
		iw(7'h27, 8'h80);
		repeat (600) @(negedge clk);
		chk("updated slot", 8'hA4, ob[7]);
		e1 = 1'b1;
		frac = 1'b0;
		repeat (600) @(negedge clk);
		chk("e1 invert", 8'h5D, ob[1]);
		chk("e1 loop", 8'hAB, ob[8]);
		chk("e1 idle", 8'h58, ob[4]);
		chk("no gap", 8'hFF, oe[4]);
		e1 = 1'b0;
		frac = 1'b1;
		wr(8'h6C, 8'h02);
		repeat (600) @(negedge clk);
		chk("off data", 8'h58, ob[4]);
		chk("off clock", 8'hFF, oe[4]);
		test_done;
	end
endmodule
`default_nettype wire

// ==== testbench/tx_pcc_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module tx_pcc_sva (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       link_clk,
	input wire logic       fractional_channel_mode,
	input wire logic       backplane_tx_clock_en
);
	// **********
	// shadow state
	// **********
	logic [2:0] cfg_q;
	logic [6:0] cnt_q;
	logic [7:0] buf_q;
	logic [7:0] adr_q;
	logic       bv_q;
	logic       av_q;
	logic       start;
	logic       rd_s;
	assign start = reg_wr && reg_addr == 8'h6E && cfg_q[1] && reg_wdata[6:0] >= 7'h20;
	assign rd_s = reg_rd && reg_addr == 8'h6D;
	// cycles since the last indirect request, parked at 7F
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			cfg_q <= 3'h0;
			cnt_q <= 7'h7F;
		end
		else
		begin
			if (reg_wr && reg_addr == 8'h6C)
				cfg_q <= reg_wdata[2:0];
			if (start)
				cnt_q <= 7'h01;
			else if (cnt_q != 7'h7F)
				cnt_q <= cnt_q + 7'h01;
		end
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			bv_q <= 1'b0;
			av_q <= 1'b0;
			buf_q <= 8'h00;
			adr_q <= 8'h00;
		end
		else if (reg_wr && reg_addr == 8'h6F)
		begin
			buf_q <= reg_wdata;
			bv_q <= 1'b1;
		end
		else if (reg_wr && reg_addr == 8'h6E)
		begin
			bv_q <= 1'b0;
			av_q <= cfg_q[1];
			adr_q <= reg_wdata;
		end
	// **********
	// checks
	// **********
	a_status_spare: assert property (@(posedge clk) disable iff (!rst_n)
		rd_s |=> reg_rdata[6:0] == 7'h00)
		else $error("status spare bits set");
	a_busy_at_start: assert property (@(posedge clk) disable iff (!rst_n)
		rd_s && cnt_q == 7'h01 |=> reg_rdata[7])
		else $error("busy low right after request");
	a_busy_bound: assert property (@(posedge clk) disable iff (!rst_n)
		rd_s && cnt_q >= 7'd64 |=> !reg_rdata[7])
		else $error("busy beyond 640 ns");
	a_ind_off_idle: assert property (@(posedge clk) disable iff (!rst_n)
		rd_s && !cfg_q[1] |=> !reg_rdata[7])
		else $error("busy with indirect mode off");
	a_cfg_readback: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == 8'h6C |=> reg_rdata == {5'h00, cfg_q})
		else $error("config readback wrong");
	a_buffer_hold: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == 8'h6F && bv_q |=> reg_rdata == buf_q)
		else $error("data buffer lost");
	a_addr_hold: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == 8'h6E && av_q |=> reg_rdata == adr_q)
		else $error("address control lost");
	a_rdata_stands: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(reg_rdata) |-> $past(reg_rd))
		else $error("read data changed unasked");
	a_gap_frac: assert property (@(posedge link_clk) disable iff (!rst_n)
		!backplane_tx_clock_en |-> $past(fractional_channel_mode, 3))
		else $error("clock gapped outside fractional mode");
	c_req: cover property (@(posedge clk) cnt_q == 7'h01);
	c_busy: cover property (@(posedge clk) rd_s ##1 reg_rdata[7]);
	c_gap: cover property (@(posedge link_clk) $fell(backplane_tx_clock_en));
endmodule
bind tx_perchannel_indirect_ctrl tx_pcc_sva tx_pcc_sva_inst (
	.clk(clk),
	.rst_n(rst_n),
	.reg_addr(reg_addr),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.link_clk(link_clk),
	.fractional_channel_mode(fractional_channel_mode),
	.backplane_tx_clock_en(backplane_tx_clock_en)
);
`default_nettype wire

// ==== testbench/tx_pcm_source.sv ====
`timescale 1ns/1ps
`default_nettype none
// free running frame of 32 slots, slot s carries 5C xor s, msb first
module tx_pcm_source (
	input wire logic  link_clk,
	input wire logic  rst_n,
	output logic [7:0] pos,
	output logic       frame,
	output logic       pcm
);
	logic [7:0] d;
	assign d = 8'h5C ^ {3'h0, pos[7:3]};
	assign frame = pos == 8'h00;
	assign pcm = d[3'h7 - pos[2:0]];
	always_ff @(posedge link_clk or negedge rst_n)
		if (!rst_n)
			pos <= 8'hFF;
		else
			pos <= pos + 8'h01;
endmodule
`default_nettype wire
